//--- tb/cgdma_cpu_model.sv
`timescale 1ns/100ps
// ****************
// CPU end of the I/O bus
// ****************
module cgdma_cpu_model (
  input wire logic clk_sys_i,
  input wire logic dma_request_out_i,
  input wire logic source_id_en_i,
  input wire logic [5:0] source_id_i,
  input wire logic dma_priority_request_i,
  output logic io_sync_o,
  output logic io_output_o,
  output logic io_command_o,
  output logic [5:0] dev_addr_o,
  output logic [15:0] data_o,
  output logic update_queue_o,
  output logic has_priority_o
);
  logic [5:0] last_id = 6'h00;
  logic prio_seen = 1'b0;
  initial begin
    io_sync_o = 1'b0;
    io_output_o = 1'b0;
    io_command_o = 1'b0;
    dev_addr_o = 6'h3f;
    data_o = 16'hffff;
    update_queue_o = 1'b0;
    has_priority_o = 1'b0;
  end
  task issue(input logic [5:0] a, input logic [15:0] w, input int hold);
    @(posedge clk_sys_i);
    #1 dev_addr_o = a;
    data_o = w;
    io_output_o = 1'b1;
    io_command_o = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 io_sync_o = 1'b1;
    repeat (hold) @(posedge clk_sys_i);
    #1 io_sync_o = 1'b0;
    @(posedge clk_sys_i);
    // Released bus shows the inverse, never a stale word
    #1 dev_addr_o = ~a;
    data_o = ~w;
    io_output_o = 1'b0;
    io_command_o = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask : issue
  task zero_term;
    issue(6'h00, 16'h0022, 4);
  endtask : zero_term
  task serve(input logic prio, output logic ok);
    int i;
    ok = 1'b0;
    last_id = 6'h00;
    prio_seen = 1'b0;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_sys_i);
      ok = (dma_request_out_i === 1'b1);
    end
    if (ok) begin
      #1 has_priority_o = prio;
      update_queue_o = 1'b1;
      // Capture the answer across the queue and the edges after its fall
      for (int k = 0; k < 7; k++) begin
        @(posedge clk_sys_i);
        if (source_id_en_i === 1'b1) last_id = source_id_i;
        if (dma_priority_request_i === 1'b1) prio_seen = 1'b1;
        if (k == 3) #1 update_queue_o = 1'b0;
      end
      #1 has_priority_o = 1'b0;
    end
  endtask : serve
endmodule : cgdma_cpu_model

//--- tb/command_gate_and_dma_request_tb.sv
`timescale 1ns/100ps
`include "cgdma_consts.svh"
module command_gate_and_dma_request_tb;
  localparam logic [5:0] ADDR = 6'h0b;
  localparam logic [1:0] RSET = 2'h2;
  localparam logic [3:0] PIDX = 4'h9;
  logic clk_sys_i = 1'b0;
  logic nrst_i, icb, ubusy, dreq, sreq, mfile, xout, ok;
  logic sync, iout, icmd, uq, prio, ssi, stb, msel, clr_n, ldc, latch, di, busy;
  logic req, preq, id_en, zen, usel;
  logic [5:0] addr, sid;
  logic [15:0] data, w;
  logic [31:0] r;
  int n_errors = 0;
  int checks = 0;
  int seed, i;
  int cnt [5];
  logic [15:0] corner [9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0012, 16'h0022,
    16'h0032, 16'h0042, 16'h0052, 16'h0062};
  always #50 clk_sys_i = ~clk_sys_i;
  cgdma_cpu_model cpu (.clk_sys_i(clk_sys_i), .dma_request_out_i(req),
    .source_id_en_i(id_en), .source_id_i(sid), .dma_priority_request_i(preq),
    .io_sync_o(sync), .io_output_o(iout), .io_command_o(icmd), .dev_addr_o(addr),
    .data_o(data), .update_queue_o(uq), .has_priority_o(prio));
  cgdma_gate #(.DEV_ADDR(ADDR), .REG_SET(RSET), .PAIR_IDX(PIDX)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .icb_i(icb), .io_sync_i(sync),
    .io_output_i(iout), .io_command_i(icmd), .dev_addr_i(addr), .output_data_bits_i(data),
    .dma_update_queue_i(uq), .unit_has_priority_i(prio), .user_busy_status_i(ubusy),
    .user_data_request_i(dreq), .store_address_request_i(sreq), .memory_file_i(mfile),
    .xfer_output_i(xout), .set_service_interrupt_o(ssi), .interrupt_strobe_o(stb),
    .mode_select_pulse_o(msel), .clear_status_pulse_n_o(clr_n), .load_command_reg_o(ldc),
    .register_io_mode_latch_o(latch), .data_interrupt_o(di), .busy_o(busy),
    .dma_request_out_o(req), .dma_priority_request_o(preq), .source_id_o(sid),
    .source_id_en_o(id_en), .zero_address_enable_o(zen), .unit_selected_o(usel));
  // ****************
  // Checking and closing
  // ****************
  task conclude;
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bit
  task chk_id(input logic [5:0] g, input logic [5:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_id
  task chk_cnt(input int g, input int e);
    checks++;
    if (g != e) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_cnt
  always @(posedge clk_sys_i) begin
    cnt[0] += int'(ssi);
    cnt[1] += int'(stb);
    cnt[2] += int'(msel);
    cnt[3] += int'(ldc);
    cnt[4] += int'(di);
    if (nrst_i) chk_bit(clr_n, ~msel);
  end
  // {set_si, strobe, mode_sel, load} pulse counts for one command
  function automatic logic [3:0] exp_cmd(input logic [15:0] c, input logic bsy);
    logic ctl, end_of_block_flag, term, nul, mode;
    ctl = !c[0] && c[1];
    end_of_block_flag = ctl && c[4];
    term = ctl && c[5];
    nul = ctl && c[6] && !end_of_block_flag && !term;
    mode = !bsy && !end_of_block_flag && !term;
    return {term && !bsy, (c[1:0] != 2'b00) && !end_of_block_flag && !term && (!bsy || nul), mode,
      mode && !nul};
  endfunction : exp_cmd
  task step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  task do_cmd(input logic [5:0] a, input logic [15:0] c, input logic bsy, input logic hit);
    logic [3:0] e;
    e = hit ? exp_cmd(c, bsy) : 4'h0;
    cnt = '{default: 0};
    cpu.issue(a, c, 4);
    chk_cnt(cnt[0], e[3]);
    chk_cnt(cnt[1], e[2]);
    chk_cnt(cnt[2], e[1]);
    chk_cnt(cnt[3], e[0]);
  endtask : do_cmd
  task wait_req(input logic e);
    for (int k = 0; k < 12 && req !== e; k++) step(1);
    if (req !== e) begin
      n_errors++;
      conclude;
    end
  endtask : wait_req
  task serve(input logic p);
    cpu.serve(p, ok);
    if (!ok) begin
      n_errors++;
      conclude;
    end
  endtask : serve
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    conclude;
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    seed = 32'h23ca;
    {nrst_i, icb, ubusy, dreq, sreq, mfile, xout} = 7'h00;
    step(2);
    nrst_i = 1'b1;
    step(2);
    chk_bit(clr_n, 1'b1);
    chk_bit(busy, 1'b0);
    chk_bit(latch, 1'b0);
    chk_bit(req, 1'b0);
    foreach (corner[j]) do_cmd(ADDR, corner[j], 1'b0, 1'b1);
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      r = $random(seed);
      if (w[1:0] == 2'b11) w[0] = 1'b0;
      if (w[1:0] != 2'b10) w[5:4] = 2'b00;
      do_cmd(r[1:0] == 2'b00 ? ADDR ^ 6'h10 : ADDR, w, 1'b0, r[1:0] != 2'b00);
    end
    ubusy = 1'b1;
    step(5);
    chk_bit(busy, 1'b1);
    foreach (corner[j]) do_cmd(ADDR, corner[j], 1'b1, 1'b1);
    ubusy = 1'b0;
    step(5);
    fork
      cpu.issue(ADDR, 16'h0002, 10);
      begin
        step(6);
        ubusy = 1'b1;
        step(5);
        chk_bit(busy, 1'b0);
      end
    join
    chk_bit(busy, 1'b1);
    ubusy = 1'b0;
    step(5);
    do_cmd(ADDR, 16'h0003, 1'b0, 1'b1);
    chk_bit(latch, 1'b1);
    serve(1'b1);
    chk_id(cpu.last_id, {RSET, `CGDMA_ID_INIT, `CGDMA_FILE_REG});
    wait_req(1'b0);
    r = $random(seed);
    xout = r[0];
    cnt = '{default: 0};
    dreq = 1'b1;
    wait_req(1'b1);
    serve(1'b0);
    chk_id(cpu.last_id, 6'h00);
    chk_bit(cpu.prio_seen, 1'b1);
    step(6);
    chk_bit(req, 1'b1);
    serve(1'b1);
    chk_id(cpu.last_id, {RSET, xout ? `CGDMA_ID_OUT : `CGDMA_ID_IN, `CGDMA_FILE_REG});
    wait_req(1'b0);
    chk_bit(zen, 1'b1);
    chk_cnt(cnt[4], 0);
    dreq = 1'b0;
    step(4);
    dreq = 1'b1;
    wait_req(1'b1);
    fork
      cpu.zero_term;
      begin
        step(6);
        chk_bit(usel, 1'b1);
      end
    join
    chk_bit(req, 1'b0);
    step(4);
    chk_bit(req, 1'b0);
    dreq = 1'b0;
    sreq = 1'b1;
    wait_req(1'b1);
    serve(1'b1);
    chk_id(cpu.last_id, {RSET, `CGDMA_ID_STAD, `CGDMA_FILE_REG});
    wait_req(1'b0);
    chk_bit(zen, 1'b0);
    sreq = 1'b0;
    do_cmd(ADDR, 16'h0001, 1'b0, 1'b1);
    chk_bit(latch, 1'b0);
    cnt = '{default: 0};
    dreq = 1'b1;
    step(6);
    chk_cnt(cnt[4], 1);
    chk_bit(req, 1'b0);
    dreq = 1'b0;
    do_cmd(ADDR, 16'h0003, 1'b0, 1'b1);
    serve(1'b1);
    ubusy = 1'b1;
    step(5);
    icb = 1'b1;
    mfile = 1'b1;
    step(5);
    icb = 1'b0;
    step(3);
    chk_bit(busy, 1'b0);
    chk_bit(latch, 1'b0);
    ubusy = 1'b0;
    step(5);
    do_cmd(ADDR, 16'h0003, 1'b0, 1'b1);
    step(4);
    chk_bit(req, 1'b0);
    sreq = 1'b1;
    step(6);
    chk_bit(req, 1'b0);
    dreq = 1'b1;
    wait_req(1'b1);
    serve(1'b1);
    chk_id(cpu.last_id, {PIDX, `CGDMA_FILE_MEM});
    wait_req(1'b0);
    step(4);
    conclude;
  end
endmodule : command_gate_and_dma_request_tb

//--- verilog/cgdma_consts.svh
`ifndef CGDMA_CONSTS_SVH
`define CGDMA_CONSTS_SVH
// ************************************************
// Command word bit positions
// ************************************************
`define CGDMA_B_D0 0
`define CGDMA_B_D1 1
`define CGDMA_B_EOB 4
`define CGDMA_B_TERM 5
`define CGDMA_B_NULL 6
`define CGDMA_DATA_W 16
// ************************************************
// Source identifier fields
// ************************************************
`define CGDMA_FILE_REG 2'h1
`define CGDMA_FILE_MEM 2'h2
`define CGDMA_ID_IN 2'h0
`define CGDMA_ID_OUT 2'h1
`define CGDMA_ID_INIT 2'h2
`define CGDMA_ID_STAD 2'h3
`define CGDMA_RST_SID 6'h00
// ************************************************
// Defaults and synchroniser width
// ************************************************
`define CGDMA_DEV_ADDR 6'h01
`define CGDMA_REG_SET 2'h0
`define CGDMA_PAIR 4'h0
`define CGDMA_SYNC_W 33
`endif

//--- verilog/cgdma_dec_if.sv
`timescale 1ns/100ps
interface cgdma_dec_if;
  logic cmd_act;
  logic busy;
  logic [15:0] data;
  logic select;
  logic control;
  logic end_of_block_flag;
  logic term;
  logic null_cmd;
  logic set_si;
  logic int_stb;
  logic mode_sel;
  logic load_cmd;
  logic dma_cmd;
  logic xfer_init;
  modport dec (input cmd_act, busy, data, output select, control, end_of_block_flag, term, null_cmd,
    set_si, int_stb, mode_sel, load_cmd, dma_cmd, xfer_init);
  modport gate (output cmd_act, busy, data, input select, control, end_of_block_flag, term, null_cmd,
    set_si, int_stb, mode_sel, load_cmd, dma_cmd, xfer_init);
endinterface : cgdma_dec_if

//--- verilog/cgdma_decode.sv
`timescale 1ns/100ps
`include "cgdma_consts.svh"
module cgdma_decode (
  cgdma_dec_if.dec d
);
  import cgdma_pkg::*;

  always_comb begin
    logic ctl;
    logic stop;
    ctl = !d.data[`CGDMA_B_D0] && d.data[`CGDMA_B_D1];
    stop = ctl && (d.data[`CGDMA_B_EOB] || d.data[`CGDMA_B_TERM]);
    d.select = d.cmd_act && !d.data[`CGDMA_B_D0] && !d.data[`CGDMA_B_D1];
    d.control = d.cmd_act && ctl;
    d.end_of_block_flag = d.control && d.data[`CGDMA_B_EOB];
    d.term = d.control && d.data[`CGDMA_B_TERM];
    d.null_cmd = d.control && d.data[`CGDMA_B_NULL] && !stop;
    d.set_si = d.term && !d.busy;
    // Null command passes even while busy
    d.int_stb = d.cmd_act && !d.select && !stop
      && (!d.busy || (d.control && d.data[`CGDMA_B_NULL]));
    d.mode_sel = d.cmd_act && !d.busy && !stop;
    d.load_cmd = d.mode_sel && !d.null_cmd;
    d.dma_cmd = d.mode_sel && d.data[`CGDMA_B_D0] && d.data[`CGDMA_B_D1];
    d.xfer_init = d.mode_sel && d.data[`CGDMA_B_D0] && !d.data[`CGDMA_B_D1];
  end
endmodule : cgdma_decode

//--- verilog/cgdma_gate.sv
`timescale 1ns/100ps
`include "cgdma_consts.svh"
module cgdma_gate #(
  parameter logic [5:0] DEV_ADDR = `CGDMA_DEV_ADDR,
  parameter logic [1:0] REG_SET = `CGDMA_REG_SET,
  parameter logic [3:0] PAIR_IDX = `CGDMA_PAIR
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic icb_i,
  input wire logic io_sync_i,
  input wire logic io_output_i,
  input wire logic io_command_i,
  input wire logic [5:0] dev_addr_i,
  input wire logic [15:0] output_data_bits_i,
  input wire logic dma_update_queue_i,
  input wire logic unit_has_priority_i,
  input wire logic user_busy_status_i,
  input wire logic user_data_request_i,
  input wire logic store_address_request_i,
  input wire logic memory_file_i,
  input wire logic xfer_output_i,
  output logic set_service_interrupt_o,
  output logic interrupt_strobe_o,
  output logic mode_select_pulse_o,
  output logic clear_status_pulse_n_o,
  output logic load_command_reg_o,
  output logic register_io_mode_latch_o,
  output logic data_interrupt_o,
  output logic busy_o,
  output logic dma_request_out_o,
  output logic dma_priority_request_o,
  output logic [5:0] source_id_o,
  output logic source_id_en_o,
  output logic zero_address_enable_o,
  output logic unit_selected_o
);
  import cgdma_pkg::*;

  // ************************************************
  // Pin synchronisation
  // ************************************************
  logic [`CGDMA_SYNC_W-1:0] pins_w;
  logic io_sync;
  logic io_out;
  logic io_cmd;
  logic uq;
  logic prio;
  logic ubusy;
  logic dreq;
  logic sreq;
  logic mem_file;
  logic xout;
  logic icb;
  logic [5:0] addr;
  logic [15:0] data;

  cgdma_sync #(
    .W(`CGDMA_SYNC_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .async_i({io_sync_i, io_output_i, io_command_i, dma_update_queue_i,
      unit_has_priority_i, user_busy_status_i, user_data_request_i,
      store_address_request_i, memory_file_i, xfer_output_i, icb_i,
      dev_addr_i, output_data_bits_i}),
    .sync_o(pins_w)
  );

  assign {io_sync, io_out, io_cmd, uq, prio, ubusy, dreq, sreq, mem_file, xout,
    icb, addr, data} = pins_w;

  // ************************************************
  // State and command decode
  // ************************************************
  cgdma_state_t st_reg;
  cgdma_state_t st_next;
  cgdma_dec_if dec_if();

  cgdma_decode u_dec (
    .d(dec_if)
  );

  logic busy_w;
  logic addr_zero;
  logic sel;
  logic cmd_lead;
  logic cmd_fall;
  logic sync_fall;
  logic ubusy_rise;
  logic dreq_rise;
  logic sreq_rise;
  logic uq_fall;
  logic xfer;
  logic zterm;
  logic any_f;

  assign busy_w = (st_reg.busy_st == CGDMA_BUSY);
  // Address zero counts only while zero enable is set
  assign addr_zero = st_reg.zero_en && (addr == 6'h00);
  assign sel = (addr == DEV_ADDR) || addr_zero;
  assign dec_if.cmd_act = sel && io_sync && io_cmd && io_out;
  assign dec_if.busy = busy_w;
  assign dec_if.data = data;

  assign cmd_lead = dec_if.cmd_act && !st_reg.cmd_prev;
  assign cmd_fall = !dec_if.cmd_act && st_reg.cmd_prev;
  assign sync_fall = !io_sync && st_reg.sync_prev;
  assign ubusy_rise = ubusy && !st_reg.ubusy_prev;
  assign dreq_rise = dreq && !st_reg.dreq_prev;
  assign sreq_rise = sreq && !st_reg.sreq_prev;
  assign uq_fall = !uq && st_reg.uq_prev;
  assign xfer = st_reg.req && !st_reg.inproc;
  // Automatic zero-address terminate from the CPU ends the transfer
  assign zterm = cmd_lead && dec_if.term && addr_zero;
  assign any_f = st_reg.init_f || st_reg.data_f || st_reg.stad_f;

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    logic init_set;
    logic data_set;
    logic stad_set;
    logic req_clr;
    logic [1:0] kind;
    init_set = cmd_lead && dec_if.dma_cmd && !mem_file;
    data_set = dreq_rise && st_reg.mode_latch;
    stad_set = sreq_rise && !mem_file;
    req_clr = (uq_fall && st_reg.prio_cap) || zterm;
    kind = `CGDMA_ID_IN;
    if (st_reg.init_s) begin
      kind = `CGDMA_ID_INIT;
    end else if (st_reg.stad_s) begin
      kind = `CGDMA_ID_STAD;
    end else if (st_reg.data_s && xout) begin
      kind = `CGDMA_ID_OUT;
    end
    st_next = st_reg;
    if (ce_i) begin
      st_next.cmd_prev = dec_if.cmd_act;
      st_next.sync_prev = io_sync;
      st_next.ubusy_prev = ubusy;
      st_next.dreq_prev = dreq;
      st_next.sreq_prev = sreq;
      st_next.uq_prev = uq;
      if (uq) begin
        st_next.prio_cap = prio;
      end
      // Busy tracking
      unique case (st_reg.busy_st)
        CGDMA_NOT_BUSY: begin
          if (ubusy_rise) begin
            st_next.busy_st = io_sync ? CGDMA_BUSY_PEND : CGDMA_BUSY;
          end
        end
        CGDMA_BUSY_PEND: begin
          // Held off so the command in flight is not cut short
          if (cmd_fall || sync_fall) begin
            st_next.busy_st = CGDMA_BUSY;
          end
        end
        CGDMA_BUSY: begin
          if (!ubusy) begin
            st_next.busy_st = CGDMA_NOT_BUSY;
          end
        end
        default: begin
          st_next.busy_st = CGDMA_NOT_BUSY;
        end
      endcase
      // Command pulses, one cycle at the command leading edge; data interrupt pulse at the data request rise while the mode latch is clear
      st_next.set_si = cmd_lead && dec_if.set_si;
      st_next.int_stb = cmd_lead && dec_if.int_stb;
      st_next.mode_sel = cmd_lead && dec_if.mode_sel;
      st_next.clr_stat_n = !(cmd_lead && dec_if.mode_sel);
      st_next.load_cmd = cmd_lead && dec_if.load_cmd;
      st_next.di_req = dreq_rise && !st_reg.mode_latch;
      // Mode latch
      if (cmd_lead && dec_if.dma_cmd) begin
        st_next.mode_latch = 1'b1;
      end else if (cmd_lead && dec_if.xfer_init) begin
        st_next.mode_latch = 1'b0;
      end
      // First rank: a new source event wins over the clear
      st_next.init_f = init_set || (st_reg.init_f && !xfer);
      st_next.data_f = data_set || (st_reg.data_f && !xfer && !zterm);
      st_next.stad_f = stad_set || (st_reg.stad_f && !xfer);
      if (xfer) begin
        st_next.init_s = st_reg.init_f;
        st_next.data_s = st_reg.data_f;
        st_next.stad_s = st_reg.stad_f;
      end
      // Request flip-flop
      // A terminate in the same cycle must not re-arm the request
      if (any_f && !st_reg.inproc && !uq && !st_reg.req && !zterm) begin
        st_next.req = 1'b1;
      end else if (req_clr) begin
        st_next.req = 1'b0;
      end
      st_next.inproc = st_reg.req;
      // Zero-address enable
      if (uq_fall && st_reg.prio_cap && st_reg.data_s) begin
        st_next.zero_en = 1'b1;
      end else if (xfer && !st_reg.data_f) begin
        st_next.zero_en = 1'b0;
      end
      // Update queue answer
      st_next.prio_out = uq && st_reg.req;
      st_next.sid_en = uq && st_reg.req && prio;
      if (mem_file) begin
        st_next.sid = {PAIR_IDX, `CGDMA_FILE_MEM};
      end else begin
        st_next.sid = {REG_SET, kind, `CGDMA_FILE_REG};
      end
      if (icb) begin
        st_next.busy_st = CGDMA_NOT_BUSY;
        st_next.mode_latch = 1'b0;
        st_next.init_f = 1'b0;
        st_next.data_f = 1'b0;
        st_next.stad_f = 1'b0;
        st_next.init_s = 1'b0;
        st_next.data_s = 1'b0;
        st_next.stad_s = 1'b0;
        st_next.req = 1'b0;
        st_next.inproc = 1'b0;
        st_next.zero_en = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.clr_stat_n <= 1'b1;
      st_reg.sid <= `CGDMA_RST_SID;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign set_service_interrupt_o = st_reg.set_si;
  assign interrupt_strobe_o = st_reg.int_stb;
  assign mode_select_pulse_o = st_reg.mode_sel;
  assign clear_status_pulse_n_o = st_reg.clr_stat_n;
  assign load_command_reg_o = st_reg.load_cmd;
  assign register_io_mode_latch_o = st_reg.mode_latch;
  assign data_interrupt_o = st_reg.di_req;
  assign busy_o = busy_w;
  assign dma_request_out_o = st_reg.req;
  assign dma_priority_request_o = st_reg.prio_out;
  assign source_id_o = st_reg.sid;
  assign source_id_en_o = st_reg.sid_en;
  assign zero_address_enable_o = st_reg.zero_en;
  assign unit_selected_o = sel;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i || !ce_i);

  set_si_pulse_a: assert property (cmd_lead && dec_if.term && !busy_w && !icb
    |=> set_service_interrupt_o) else $error("set service interrupt missing");
  int_strobe_a: assert property (cmd_lead && !dec_if.select && !dec_if.end_of_block_flag
    && !dec_if.term && !busy_w |=> interrupt_strobe_o)
    else $error("interrupt strobe missing");
  null_load_a: assert property (cmd_lead && dec_if.null_cmd |=> !load_command_reg_o)
    else $error("null command loaded");
  mode_busy_a: assert property (mode_select_pulse_o |-> $past(busy_w) == 1'b0)
    else $error("mode select while busy");
  clr_status_a: assert property (clear_status_pulse_n_o != mode_select_pulse_o)
    else $error("clear status not complement");
  busy_set_a: assert property (ubusy_rise && !io_sync && !icb
    && st_reg.busy_st == CGDMA_NOT_BUSY |=> busy_o)
    else $error("busy not set");
  latch_set_a: assert property (cmd_lead && dec_if.dma_cmd && !icb
    |=> register_io_mode_latch_o) else $error("mode latch not set");
  route_dma_a: assert property (dreq_rise && st_reg.mode_latch
    |=> !data_interrupt_o) else $error("data interrupt in dma mode");
  latch_clr_a: assert property (cmd_lead && dec_if.xfer_init
    |=> !register_io_mode_latch_o) else $error("mode latch not cleared");
  mem_file_a: assert property (mem_file && st_reg.init_f == 1'b0 && !xfer
    |=> !st_reg.init_f) else $error("init source in memory file");
  req_set_a: assert property (any_f && !st_reg.inproc && !uq && !st_reg.req && !icb
    && !zterm |=> dma_request_out_o ##1 st_reg.inproc)
    else $error("request or in-process not set");
  id_prio_a: assert property (source_id_en_o |-> dma_priority_request_o)
    else $error("identifier without priority bit");
  req_hold_a: assert property (uq_fall && !st_reg.prio_cap && st_reg.req && !zterm
    && !icb |=> dma_request_out_o) else $error("request dropped");
  zero_en_a: assert property (uq_fall && st_reg.prio_cap && st_reg.data_s && !icb
    |=> zero_address_enable_o) else $error("zero enable not set");
  zterm_a: assert property (zterm && !icb |=> !dma_request_out_o)
    else $error("zero terminate left request");
  load_cmd_a: assert property (cmd_lead && dec_if.mode_sel && !dec_if.null_cmd
    |=> load_command_reg_o) else $error("load command missing");
  busy_block_a: assert property (cmd_lead && busy_w |=> !mode_select_pulse_o
    && !load_command_reg_o && !set_service_interrupt_o)
    else $error("command passed while busy");
  flag_move_a: assert property (xfer && st_reg.data_f && !icb
    |=> st_reg.data_s && st_reg.inproc) else $error("flag not moved");
  zterm_flag_a: assert property (zterm && !dreq_rise && !icb |=> !st_reg.data_f)
    else $error("data flag kept after terminate");
  // Identifier fields checked against the state one cycle back, where they were formed
  stad_id_a: assert property (source_id_en_o && $past(st_reg.stad_s)
    && !$past(st_reg.init_s) && !$past(mem_file)
    |-> source_id_o[3:2] == `CGDMA_ID_STAD) else $error("store id kind wrong");
  mem_id_a: assert property (source_id_en_o && $past(mem_file)
    |-> source_id_o == {PAIR_IDX, `CGDMA_FILE_MEM}) else $error("memory id wrong");

  dma_cmd_c: cover property (cmd_lead && dec_if.dma_cmd);
  grant_c: cover property (uq_fall && st_reg.prio_cap && st_reg.req);
  zterm_c: cover property (zterm);
  busy_pend_c: cover property (st_reg.busy_st == CGDMA_BUSY_PEND);
  null_cmd_c: cover property (cmd_lead && dec_if.null_cmd);
endmodule : cgdma_gate

//--- verilog/cgdma_pkg.sv
package cgdma_pkg;
  typedef enum logic [1:0] {CGDMA_NOT_BUSY, CGDMA_BUSY_PEND, CGDMA_BUSY} cgdma_busy_t;
  typedef struct packed {
    cgdma_busy_t busy_st;
    logic cmd_prev;
    logic sync_prev;
    logic ubusy_prev;
    logic dreq_prev;
    logic sreq_prev;
    logic uq_prev;
    logic prio_cap;
    logic mode_latch;
    logic init_f;
    logic data_f;
    logic stad_f;
    logic init_s;
    logic data_s;
    logic stad_s;
    logic req;
    logic inproc;
    logic zero_en;
    logic set_si;
    logic int_stb;
    logic mode_sel;
    logic clr_stat_n;
    logic load_cmd;
    logic di_req;
    logic [5:0] sid;
    logic sid_en;
    logic prio_out;
  } cgdma_state_t;
endpackage : cgdma_pkg

//--- verilog/cgdma_sync.sv
`timescale 1ns/100ps
module cgdma_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import cgdma_pkg::*;
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } cgdma_sync_t;
  cgdma_sync_t st_reg;
  cgdma_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.s1 = async_i;
      st_next.s2 = st_reg.s1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.s2;
endmodule : cgdma_sync
